/* rtl/camf_cfg.svh */
// Register map, field positions, reset values and encodings for the CAN mask and TX FIFO control block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and word-aligned registers.
`ifndef CAMF_CFG_SVH
`define CAMF_CFG_SVH

`define CAMF_NFIFO          4
`define CAMF_NMASK          4

`define CAMF_OFF_CTRL       8'h00
`define CAMF_OFF_FRST       8'h30
`define CAMF_OFF_ISTAT      8'h34
`define CAMF_OFF_IMASK      8'h38
`define CAMF_REGION_MASK    4'h1
`define CAMF_REGION_FIFO    4'h2

`define CAMF_MODE_MSB       23
`define CAMF_MODE_LSB       21
`define CAMF_MODE_CONFIG    3'h4
`define CAMF_MODE_RESET     3'h4

`define CAMF_SID_MSB        31
`define CAMF_SID_LSB        21
`define CAMF_IDENT_TYPE_MATCH_BIT       19
`define CAMF_EID_MSB        17
`define CAMF_EID_LSB        0
`define CAMF_MASK_IMPL      32'hFFEBFFFF

`define CAMF_F_FIFO_DIRECTION_TRANSMIT         7
`define CAMF_F_ABAT         6
`define CAMF_F_LARB         5
`define CAMF_F_ERR          4
`define CAMF_F_REQ          3
`define CAMF_F_AUTO_REMOTE_REPLY_ENABLE        2
`define CAMF_F_PRIO_MSB     1
`define CAMF_F_PRIO_LSB     0

`define CAMF_NINT           5
`define CAMF_I_SENT         0
`define CAMF_I_ABORT        1
`define CAMF_I_LARB         2
`define CAMF_I_BUSERR       3
`define CAMF_I_RTR          4

`endif

/* rtl/camf_pkg.sv */
// Types shared by the mask store and the control block.
// Assumes camf_cfg.svh is on the include path.
`include "camf_cfg.svh"

package camf_pkg;

   // Register read pipeline: address, registered data, accept
   typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_READY} camf_rd_t;

   typedef struct packed {
      logic [`CAMF_NMASK-1:0][31:0] word;
      logic [31:0]                  rdA;
      logic [31:0]                  rdB;
   } camf_mem_t;

   typedef struct packed {
      logic [2:0]                   opMode;
      logic [`CAMF_NFIFO-1:0]       fifo_direction_transmit;
      logic [`CAMF_NFIFO-1:0]       auto_remote_reply_enable;
      logic [`CAMF_NFIFO-1:0]       req;
      logic [`CAMF_NFIFO-1:0]       abat;
      logic [`CAMF_NFIFO-1:0]       larb;
      logic [`CAMF_NFIFO-1:0]       err;
      logic [`CAMF_NFIFO-1:0][1:0]  prio;
      logic [`CAMF_NINT-1:0]        intStat;
      logic [`CAMF_NINT-1:0]        intMask;
      camf_rd_t                     rdPhase;
      logic [31:0]                  rdData;
      logic                         txActive;
      logic [1:0]                   txFifo;
      logic                         filtPend;
      logic [10:0]                  fSid;
      logic [10:0]                  vSid;
      logic [17:0]                  fEid;
      logic [17:0]                  vEid;
      logic                         fIde;
      logic                         vExid;
      logic                         fDone;
      logic                         fMatch;
   } camf_state_t;

   localparam camf_state_t CAMF_STATE_RST = '{opMode: `CAMF_MODE_RESET, rdPhase: RD_IDLE, default: '0};

   // Byte-lane merge of a write into an existing word
   function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

endpackage

/* rtl/camf_mask_mem.sv */
// Storage for the four acceptance mask words, one write port and two registered read ports.
// Assumes the caller gates writes by operating mode; unimplemented bits are stored as zero.
`timescale 1ns/100ps
`include "camf_cfg.svh"

module camf_mask_mem (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        we,
   input  wire logic [1:0]  wAddr,
   input  wire logic [31:0] wData,
   input  wire logic [3:0]  wBe,
   input  wire logic [1:0]  rAddrA,
   input  wire logic [1:0]  rAddrB,
   output      logic [31:0] rDataA,
   output      logic [31:0] rDataB
);

   camf_pkg::camf_mem_t m_r;
   camf_pkg::camf_mem_t m_nxt;

   always_comb begin
      m_nxt = m_r;
      if (we) begin
         m_nxt.word[wAddr] = camf_pkg::merge_be(m_r.word[wAddr], wData, wBe) & `CAMF_MASK_IMPL;
      end
      m_nxt.rdA = m_r.word[rAddrA];
      m_nxt.rdB = m_r.word[rAddrB];
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         m_r <= '0;
      end else begin
         m_r <= m_nxt;
      end
   end

   assign rDataA = m_r.rdA;
   assign rDataB = m_r.rdB;

endmodule

/* rtl/camf_ctrl.sv */
// CAN acceptance mask registers and transmit FIFO control/status, with an Avalon-MM register slave.
// Assumes a CAN protocol engine on the same clock that sends the selected FIFO and reports outcomes as pulses.
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/100ps
`include "camf_cfg.svh"

module camf_ctrl (
   input  wire logic                   clk,
   input  wire logic                   reset,
   // Avalon-MM slave
   input  wire logic [7:0]             address,
   input  wire logic                   read,
   input  wire logic                   write,
   input  wire logic [31:0]            writedata,
   input  wire logic [3:0]             byteenable,
   output      logic [31:0]            readdata,
   output      logic                   waitrequest,
   output      logic                   irq,
   // Transmit engine
   output      logic                   txValid,
   output      logic [1:0]             txFifoSel,
   output      logic                   txAbortReq,
   input  wire logic                   txMsgSent,
   input  wire logic                   txLastMsg,
   input  wire logic                   txAborted,
   input  wire logic                   txLostArb,
   input  wire logic                   txBusErr,
   input  wire logic                   rtrRx,
   input  wire logic [1:0]             rtrFifo,
   input  wire logic [`CAMF_NFIFO-1:0] fifoReset,
   // Acceptance filter compare
   input  wire logic                   filtReq,
   input  wire logic [1:0]             filtMaskSel,
   input  wire logic [10:0]            frameSid,
   input  wire logic [17:0]            frameEid,
   input  wire logic                   frameIde,
   input  wire logic [10:0]            fltSid,
   input  wire logic [17:0]            fltEid,
   input  wire logic                   fltExid,
   output      logic                   filtDone,
   output      logic                   filtMatch
);

   camf_pkg::camf_state_t s_r;
   camf_pkg::camf_state_t s_nxt;

   logic [31:0] maskRdA;
   logic [31:0] maskRdB;
   logic        maskWe;
   logic        cfgMode;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic isFifo(input logic [7:0] a);
      return a[7:4] == `CAMF_REGION_FIFO;
   endfunction

   function automatic logic isMask(input logic [7:0] a);
      return a[7:4] == `CAMF_REGION_MASK;
   endfunction

   function automatic logic [31:0] fifoWord(input camf_pkg::camf_state_t s, input logic [1:0] f);
      logic [31:0] w;
      w = '0;
      w[`CAMF_F_FIFO_DIRECTION_TRANSMIT]                         = s.fifo_direction_transmit[f];
      w[`CAMF_F_ABAT]                         = s.abat[f];
      w[`CAMF_F_LARB]                         = s.larb[f];
      w[`CAMF_F_ERR]                          = s.err[f];
      w[`CAMF_F_REQ]                          = s.req[f];
      w[`CAMF_F_AUTO_REMOTE_REPLY_ENABLE]                        = s.auto_remote_reply_enable[f];
      w[`CAMF_F_PRIO_MSB:`CAMF_F_PRIO_LSB]    = s.prio[f];
      return w;
   endfunction

   // Highest code wins; equal codes go to the lowest index
   function automatic logic [2:0] pickFifo(input camf_pkg::camf_state_t s);
      logic [2:0] r;
      logic [1:0] best;
      r = '0;
      best = '0;
      for (int i = 0; i < `CAMF_NFIFO; i++) begin
         if (s.fifo_direction_transmit[i] && s.req[i] && (!r[2] || s.prio[i] > best)) begin
            r = {1'b1, i[1:0]};
            best = s.prio[i];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Mask store

   assign cfgMode = s_r.opMode == `CAMF_MODE_CONFIG;
   assign maskWe  = write && isMask(address) && cfgMode;

   camf_mask_mem u_mask (
      .clk    (clk),
      .reset  (reset),
      .we     (maskWe),
      .wAddr  (address[3:2]),
      .wData  (writedata),
      .wBe    (byteenable),
      .rAddrA (address[3:2]),
      .rAddrB (filtMaskSel),
      .rDataA (maskRdA),
      .rDataB (maskRdB)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic [31:0] wd;
      logic [1:0]  fa;
      logic [1:0]  tf;
      logic [2:0]  pick;
      logic [10:0] mSid;
      logic [17:0] mEid;
      logic        sidOk;
      logic        eidOk;
      logic        rdDone;
      wd     = '0;
      fa     = address[3:2];
      tf     = s_r.txFifo;
      pick   = '0;
      mSid   = maskRdB[`CAMF_SID_MSB:`CAMF_SID_LSB];
      mEid   = maskRdB[`CAMF_EID_MSB:`CAMF_EID_LSB];
      sidOk  = ((s_r.fSid ^ s_r.vSid) & mSid) == '0;
      eidOk  = ((s_r.fEid ^ s_r.vEid) & mEid) == '0;
      rdDone = read && s_r.rdPhase == camf_pkg::RD_READY;
      s_nxt  = s_r;

      // Read pipeline: address, then registered data, then accept
      case (s_r.rdPhase)
         camf_pkg::RD_IDLE: begin
            if (read) begin
               s_nxt.rdPhase = camf_pkg::RD_FETCH;
            end
         end
         camf_pkg::RD_FETCH: begin
            s_nxt.rdPhase = camf_pkg::RD_READY;
            if (isMask(address)) begin
               s_nxt.rdData = maskRdA;
            end else if (isFifo(address)) begin
               s_nxt.rdData = fifoWord(s_r, fa);
            end else if (address == `CAMF_OFF_CTRL) begin
               s_nxt.rdData = '0;
               s_nxt.rdData[`CAMF_MODE_MSB:`CAMF_MODE_LSB] = s_r.opMode;
            end else if (address == `CAMF_OFF_ISTAT) begin
               s_nxt.rdData = {{(32-`CAMF_NINT){1'b0}}, s_r.intStat};
            end else if (address == `CAMF_OFF_IMASK) begin
               s_nxt.rdData = {{(32-`CAMF_NINT){1'b0}}, s_r.intMask};
            end else begin
               s_nxt.rdData = '0;
            end
         end
         camf_pkg::RD_READY: begin
            s_nxt.rdPhase = camf_pkg::RD_IDLE;
         end
         default: begin
            s_nxt.rdPhase = camf_pkg::RD_IDLE;
         end
      endcase

      // Clears first, so that same-cycle hardware events below win
      if (rdDone && isFifo(address)) begin
         s_nxt.larb[fa] = 1'b0;
         s_nxt.err[fa]  = 1'b0;
      end

      if (write) begin
         if (address == `CAMF_OFF_CTRL) begin
            wd = camf_pkg::merge_be({8'h00, s_r.opMode, 21'h0}, writedata, byteenable);
            s_nxt.opMode = wd[`CAMF_MODE_MSB:`CAMF_MODE_LSB];
         end else if (address == `CAMF_OFF_ISTAT && byteenable[0]) begin
            s_nxt.intStat = s_r.intStat & ~writedata[`CAMF_NINT-1:0];
         end else if (address == `CAMF_OFF_IMASK && byteenable[0]) begin
            s_nxt.intMask = writedata[`CAMF_NINT-1:0];
         end else if (isFifo(address) && byteenable[0]) begin
            if (cfgMode) begin
               s_nxt.fifo_direction_transmit[fa]  = writedata[`CAMF_F_FIFO_DIRECTION_TRANSMIT];
               s_nxt.auto_remote_reply_enable[fa] = writedata[`CAMF_F_AUTO_REMOTE_REPLY_ENABLE];
               s_nxt.prio[fa]  = writedata[`CAMF_F_PRIO_MSB:`CAMF_F_PRIO_LSB];
            end
            // Only a FIFO already set to transmit before the write takes a request; clearing a set bit is the abort request
            if (s_r.fifo_direction_transmit[fa]) begin
               s_nxt.req[fa] = writedata[`CAMF_F_REQ];
            end
         end
      end

      // Software FIFO reset (pulse per FIFO from the surrounding controller)
      for (int i = 0; i < `CAMF_NFIFO; i++) begin
         if (fifoReset[i]) begin
            s_nxt.req[i]  = 1'b0;
            s_nxt.abat[i] = 1'b0;
            s_nxt.larb[i] = 1'b0;
            s_nxt.err[i]  = 1'b0;
         end
      end

      // Outcomes reported by the engine for the FIFO it was given
      if (s_r.txActive) begin
         if (txMsgSent) begin
            s_nxt.abat[tf] = 1'b0;
            s_nxt.txActive = 1'b0;
            if (txLastMsg) begin
               s_nxt.req[tf] = 1'b0;
               s_nxt.intStat[`CAMF_I_SENT] = 1'b1;
            end
         end
         if (txAborted) begin
            s_nxt.abat[tf] = 1'b1;
            s_nxt.req[tf]  = 1'b0;
            s_nxt.txActive = 1'b0;
            s_nxt.intStat[`CAMF_I_ABORT] = 1'b1;
         end
         // Losing arbitration or an error frees the slot so priorities are re-evaluated
         if (txLostArb) begin
            s_nxt.larb[tf] = 1'b1;
            s_nxt.txActive = 1'b0;
            s_nxt.intStat[`CAMF_I_LARB] = 1'b1;
         end
         if (txBusErr) begin
            s_nxt.err[tf]  = 1'b1;
            s_nxt.txActive = 1'b0;
            s_nxt.intStat[`CAMF_I_BUSERR] = 1'b1;
         end
      end else begin
         pick = pickFifo(s_r);
         if (pick[2]) begin
            s_nxt.txActive = 1'b1;
            s_nxt.txFifo   = pick[1:0];
         end
      end

      if (rtrRx && s_r.auto_remote_reply_enable[rtrFifo] && s_r.fifo_direction_transmit[rtrFifo]) begin
         s_nxt.req[rtrFifo] = 1'b1;
         s_nxt.intStat[`CAMF_I_RTR] = 1'b1;
      end

      // Filter compare: capture the frame, the mask word arrives a cycle later
      s_nxt.filtPend = filtReq;
      if (filtReq) begin
         s_nxt.fSid  = frameSid;
         s_nxt.fEid  = frameEid;
         s_nxt.fIde  = frameIde;
         s_nxt.vSid  = fltSid;
         s_nxt.vEid  = fltEid;
         s_nxt.vExid = fltExid;
      end
      s_nxt.fDone = s_r.filtPend;
      if (s_r.filtPend) begin
         if (maskRdB[`CAMF_IDENT_TYPE_MATCH_BIT]) begin
            s_nxt.fMatch = (s_r.fIde == s_r.vExid) && sidOk && (!s_r.fIde || eidOk);
         end else begin
            s_nxt.fMatch = sidOk && (!s_r.fIde || eidOk);
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_r <= camf_pkg::CAMF_STATE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Outputs

   // Writes never stall; reads stall until the registered data is ready
   assign waitrequest = read && s_r.rdPhase != camf_pkg::RD_READY;
   assign readdata    = s_r.rdData;
   assign irq         = |(s_r.intStat & s_r.intMask);
   assign txValid     = s_r.txActive;
   assign txFifoSel   = s_r.txFifo;
   assign txAbortReq  = s_r.txActive && !s_r.req[s_r.txFifo];
   assign filtDone    = s_r.fDone;
   assign filtMatch   = s_r.fMatch;

endmodule

/* tb/camf_ctrl_monitor.sv */
// Port-level checker for the mask and transmit FIFO control block.
// Assumes one clock domain and the register bus timing given by the designer.
`timescale 1ns/100ps
module camf_ctrl_monitor (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [7:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic        irq,
   input wire logic        txValid,
   input wire logic [1:0]  txFifoSel,
   input wire logic        txAbortReq,
   input wire logic        txMsgSent,
   input wire logic        txAborted,
   input wire logic        txLostArb,
   input wire logic        txBusErr,
   input wire logic        filtReq,
   input wire logic        filtDone
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   logic outcome;
   assign outcome = txMsgSent | txAborted | txLostArb | txBusErr;
   ////////////////////////////////////////////////////////////
   a_read_wait:
      assert property ($rose(read) |-> waitrequest ##1 waitrequest ##1 !waitrequest) else $error("read wait count wrong");
   a_write_nowait:
      assert property (write |-> !waitrequest) else $error("write was stalled");
   a_filt_answer:
      assert property (filtReq |-> ##2 filtDone) else $error("filter answer late");
   a_filt_cause:
      assert property (filtDone |-> $past(filtReq, 2)) else $error("filter answer without request");
   a_abort_cause:
      assert property (txAbortReq |-> txValid) else $error("abort request while idle");
   a_sel_hold:
      assert property (txValid && !outcome |=> txValid && $stable(txFifoSel)) else $error("selection moved");
   a_outcome_drop:
      assert property (txValid && outcome |=> !txValid) else $error("presentation kept after outcome");
   a_fall_cause:
      assert property ($fell(txValid) |-> $past(outcome)) else $error("selection dropped without outcome");
   a_mask_reserved:
      assert property (read && !waitrequest && address[7:4] == 4'h1 |-> readdata[20] == 1'b0 && readdata[18] == 1'b0)
         else $error("reserved mask bit reads one");
   c_abort: cover property (txAbortReq);
   c_filt: cover property (filtDone);
   c_irq: cover property (irq);
endmodule

bind camf_ctrl camf_ctrl_monitor u_camf_ctrl_monitor (.clk(clk), .reset(reset), .address(address), .read(read),
   .write(write), .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .txValid(txValid),
   .txFifoSel(txFifoSel), .txAbortReq(txAbortReq), .txMsgSent(txMsgSent), .txAborted(txAborted),
   .txLostArb(txLostArb), .txBusErr(txBusErr), .filtReq(filtReq), .filtDone(filtDone));

/* tb/camf_tx_engine_model.sv */
// Behavioural CAN transmit engine standing for the bus side.
// Answers dly+1 cycles after a FIFO is presented; fault picks sent, lost arbitration or bus error.
`timescale 1ns/100ps
module camf_tx_engine_model (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       txValid,
   input  wire logic       txAbortReq,
   input  wire logic [1:0] fault,
   input  wire logic [7:0] dly,
   output      logic       txMsgSent,
   output      logic       txLastMsg,
   output      logic       txAborted,
   output      logic       txLostArb,
   output      logic       txBusErr
);
   logic [7:0] cnt;
   // At most one outcome per presentation (fault 3 gives none); count parks at FF so dly must stay below it
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt <= 8'h00;
         {txMsgSent, txLastMsg, txAborted, txLostArb, txBusErr} <= 5'h00;
      end else begin
         {txMsgSent, txLastMsg, txAborted, txLostArb, txBusErr} <= 5'h00;
         if (!txValid) begin
            cnt <= 8'h00;
         end else if (cnt <= dly) begin
            cnt <= (txAbortReq || cnt == dly) ? 8'hFF : cnt + 8'h01;
            if (txAbortReq) begin
               txAborted <= 1'b1;
            end else if (cnt == dly) begin
               txMsgSent <= fault == 2'h0;
               txLastMsg <= fault == 2'h0;
               txLostArb <= fault == 2'h1;
               txBusErr  <= fault == 2'h2;
            end
         end
      end
   end
endmodule

/* tb/can_accept_mask_tx_fifo_ctrl_tb.sv */
// Self-checking bench: filter table, register access, transmit control and interrupts.
// Assumes the register offsets of camf_cfg.svh and the engine model beside the design.
`timescale 1ns/100ps
module can_accept_mask_tx_fifo_ctrl_tb;
   typedef struct packed {
      logic [31:0] msk;
      logic [10:0] fSid;
      logic [17:0] fEid;
      logic        fExid;
      logic [10:0] mSid;
      logic [17:0] mEid;
      logic        ident_type_match;
      logic        exp;
   } camf_row_t;
   camf_row_t rows [9] = '{
      '{32'hFFF40000, 11'h123, 18'h0, 1'h0, 11'h123, 18'h0, 1'h0, 1'h1},
      '{32'hFFE00000, 11'h123, 18'h0, 1'h0, 11'h124, 18'h0, 1'h0, 1'h0},
      '{32'hFFC00000, 11'h124, 18'h0, 1'h0, 11'h125, 18'h0, 1'h0, 1'h1},
      '{32'hFFE80000, 11'h123, 18'h0, 1'h0, 11'h123, 18'h0, 1'h1, 1'h0},
      '{32'hFFE80000, 11'h123, 18'h0, 1'h0, 11'h123, 18'h0, 1'h0, 1'h1},
      '{32'hFFE3FFFF, 11'h123, 18'h1, 1'h1, 11'h123, 18'h0, 1'h1, 1'h0},
      '{32'hFFE3FFFE, 11'h123, 18'h1, 1'h1, 11'h123, 18'h0, 1'h1, 1'h1},
      '{32'hFFEBFFFF, 11'h123, 18'h2AAAA, 1'h1, 11'h123, 18'h2AAAA, 1'h1, 1'h1},
      '{32'hFFE3FFFF, 11'h123, 18'h3, 1'h0, 11'h123, 18'h3, 1'h1, 1'h1}};
   logic        clk, reset, read, write, rtrRx, filtReq, frameIde, fltExid, irq, filtDone, filtMatch;
   logic        txValid, txAbortReq, txMsgSent, txLastMsg, txAborted, txLostArb, txBusErr, waitrequest;
   logic [1:0]  rtrFifo, filtMaskSel, fault, txFifoSel;
   logic [3:0]  fifoReset;
   logic [7:0]  address, dly;
   logic [10:0] frameSid, fltSid;
   logic [17:0] frameEid, fltEid;
   logic [31:0] writedata, readdata, rv;
   int          err_total, checked, cycles;

   camf_ctrl u_camf_ctrl (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
      .txValid(txValid), .txFifoSel(txFifoSel), .txAbortReq(txAbortReq), .txMsgSent(txMsgSent),
      .txLastMsg(txLastMsg), .txAborted(txAborted), .txLostArb(txLostArb), .txBusErr(txBusErr),
      .rtrRx(rtrRx), .rtrFifo(rtrFifo), .fifoReset(fifoReset), .filtReq(filtReq), .filtMaskSel(filtMaskSel),
      .frameSid(frameSid), .frameEid(frameEid), .frameIde(frameIde), .fltSid(fltSid), .fltEid(fltEid),
      .fltExid(fltExid), .filtDone(filtDone), .filtMatch(filtMatch));
   camf_tx_engine_model u_camf_tx_engine_model (.clk(clk), .reset(reset), .txValid(txValid),
      .txAbortReq(txAbortReq), .fault(fault), .dly(dly), .txMsgSent(txMsgSent), .txLastMsg(txLastMsg),
      .txAborted(txAborted), .txLostArb(txLostArb), .txBusErr(txBusErr));
   ////////////////////////////////////////////////////////////
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("checked=%0d err_total=%0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      address   <= a;
      writedata <= d;
      write     <= 1'b1;
      do @(posedge clk); while (waitrequest);
      write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      address <= a;
      read    <= 1'b1;
      do @(posedge clk); while (waitrequest);
      d = readdata;
      read <= 1'b0;
   endtask
   task automatic waitv(input logic lvl);
      int n;
      n = 0;
      while (txValid !== lvl && n < 300) begin
         @(posedge clk);
         n++;
      end
      cmp({31'h0, txValid}, {31'h0, lvl});
   endtask
   task automatic pulse_rtr(input logic [1:0] f);
      @(posedge clk);
      rtrRx   <= 1'b1;
      rtrFifo <= f;
      @(posedge clk);
      rtrRx <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         conclude();
      end
   end
   initial begin
      {reset, read, write, rtrRx, filtReq, frameIde, fltExid} = 7'h40;
      {rtrFifo, filtMaskSel, fault, fifoReset, address, dly} = 26'h0;
      {frameSid, fltSid, frameEid, fltEid, writedata} = 90'h0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      rd(8'h10, rv);
      cmp(rv, 32'h0);
      cmp({30'h0, irq, txValid}, 32'h0);
      rd(8'h00, rv);
      cmp({29'h0, rv[23:21]}, 32'h4);
      for (int i = 0; i < 9; i++) begin
         wr(8'h10 + 8'(i % 4 * 4), rows[i].msk);
         rd(8'h10 + 8'(i % 4 * 4), rv);
         cmp(rv, rows[i].msk & 32'hFFEBFFFF);
         @(posedge clk);
         filtReq     <= 1'b1;
         filtMaskSel <= 2'(i % 4);
         {fltSid, fltEid, fltExid, frameSid, frameEid, frameIde} <= rows[i][60:1];
         @(posedge clk);
         filtReq <= 1'b0;
         repeat (2) @(posedge clk);
         cmp({30'h0, filtDone, filtMatch}, {30'h0, 1'b1, rows[i].exp});
      end
      wr(8'h20, 32'h81);
      wr(8'h24, 32'h83);
      wr(8'h28, 32'h04);
      wr(8'h2C, 32'h84);
      wr(8'h38, 32'h1F);
      wr(8'h00, 32'h0);
      wr(8'h10, 32'hFFFFFFFF);
      rd(8'h10, rv);
      cmp(rv, 32'hFFE3FFFF);
      wr(8'h20, 32'h02);
      rd(8'h20, rv);
      cmp(rv, 32'h81);
      wr(8'h28, 32'h0C);
      rd(8'h28, rv);
      cmp(rv, 32'h04);
      cmp({31'h0, txValid}, 32'h0);
      // Keep the engine busy so both requests wait for the same arbitration
      dly <= 8'h28;
      wr(8'h2C, 32'h8C);
      waitv(1'b1);
      wr(8'h20, 32'h89);
      wr(8'h24, 32'h8B);
      waitv(1'b0);
      waitv(1'b1);
      cmp({30'h0, txFifoSel}, 32'h1);
      waitv(1'b0);
      waitv(1'b1);
      cmp({30'h0, txFifoSel}, 32'h0);
      waitv(1'b0);
      rd(8'h24, rv);
      cmp(rv, 32'h83);
      wr(8'h38, 32'h0);
      @(posedge clk);
      cmp({31'h0, irq}, 32'h0);
      wr(8'h38, 32'h1F);
      @(posedge clk);
      cmp({31'h0, irq}, 32'h1);
      wr(8'h34, 32'h1F);
      @(posedge clk);
      cmp({31'h0, irq}, 32'h0);
      dly <= 8'h64;
      wr(8'h20, 32'h89);
      waitv(1'b1);
      wr(8'h20, 32'h81);
      waitv(1'b0);
      rd(8'h20, rv);
      cmp(rv, 32'hC1);
      @(posedge clk);
      fifoReset <= 4'h1;
      @(posedge clk);
      fifoReset <= 4'h0;
      rd(8'h20, rv);
      cmp(rv, 32'h81);
      dly <= 8'h05;
      for (int k = 1; k < 3; k++) begin
         fault <= 2'(k);
         wr(8'h2C, 32'h8C);
         waitv(1'b1);
         waitv(1'b0);
         fault <= 2'h0;
         waitv(1'b1);
         waitv(1'b0);
         rd(8'h2C, rv);
         cmp(rv, k == 1 ? 32'hA4 : 32'h94);
         rd(8'h2C, rv);
         cmp(rv, 32'h84);
      end
      dly <= 8'h1E;
      pulse_rtr(2'h3);
      rd(8'h2C, rv);
      cmp(rv, 32'h8C);
      waitv(1'b0);
      pulse_rtr(2'h0);
      pulse_rtr(2'h2);
      rd(8'h20, rv);
      cmp(rv, 32'h81);
      rd(8'h28, rv);
      cmp(rv, 32'h04);
      rd(8'h3C, rv);
      cmp(rv, 32'h0);
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rd(8'h10, rv);
      cmp(rv, 32'h0);
      conclude();
   end
endmodule
